//--- shared/dma_flow_map.svh
// Operation
// - Transfer only when enabled, no blocking flags.
// - Each accepted request moves one unit, count-1.
// - Auto mode requests internally once enabled.
// - Count reaching zero ends transfer normally.
// - Normal end raises interrupt when enabled.
// - Address error or NMI aborts transfers.
// - Clearing channel or master enable aborts.
// - Four-bit source field selects request mode.
// - Detect select picks low level or falling edge.
// - External source encodings 0000, 0010, 0011.
// - On-chip encodings: serial, timer, converter sources.
// - Cycle-steal withdraws module request at first unit.
// - Burst withdraws module request at last unit.
// - Requester need not be source or destination.
// - Edge sensing only in burst with edge select.
// - Start by priority, end on end conditions.
// - End flag only on normal end; read-then-clear.
// - Priority field: two fixed, two round-robin orders.
// - Error and NMI flags block until cleared.
`ifndef DMA_FLOW_MAP_SVH
`define DMA_FLOW_MAP_SVH

// Register map
`define CH_CTRL_BASE 8'h00
`define CH_COUNT_BASE 8'h04
`define CH_STRIDE 8'h10
`define GLOBAL_OP_OFS 8'h40

// Channel control fields
`define CTRL_ENABLE_BIT 0
`define CTRL_END_BIT 1
`define CTRL_IE_BIT 2
`define CTRL_SIZE_BIT 3
`define CTRL_BURST_BIT 4
`define CTRL_DETECT_BIT 6
`define CTRL_SRC_LSB 8
`define CTRL_SRC_MSB 11
`define CTRL_WMASK 16'h0F5D
`define CTRL_RESET 16'h0000
`define COUNT_RESET 16'h0000

// Global operation fields
`define GOP_MASTER_BIT 0
`define GOP_NMI_BIT 1
`define GOP_AE_BIT 2
`define GOP_PRIO_LSB 8
`define GOP_PRIO_MSB 9
`define PRIO_RESET 2'h0
`define RR_RESET_POS 2'h0

// Request source encodings
`define SRC_EXT_DUAL 4'h0
`define SRC_EXT_TO_DEV 4'h2
`define SRC_EXT_FROM_DEV 4'h3
`define SRC_SER0_RX 4'h4
`define SRC_TIMER3 4'hB
`define SRC_CONV_END 4'hD

// Priority modes
`define PRIO_FIXED0 2'h0
`define PRIO_FIXED1 2'h1
`define PRIO_RROBIN 2'h2
`define PRIO_EXT_RR 2'h3

`endif

//--- shared/dma_flow_pkg.sv
`default_nettype none
package dma_flow_pkg;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } flow_state_t;

  typedef struct packed {
    logic [3:0][15:0] ctrl;
    logic [3:0][15:0] count;
    logic [3:0] teSeen;
    logic [3:0] irq;
    logic masterEn;
    logic nmiFlag;
    logic addrErrFlag;
    logic nmiSeen;
    logic aeSeen;
    logic [1:0] prioSel;
    logic [1:0] rrPos;
    logic ch0Low;
    flow_state_t state;
    logic [1:0] curCh;
    logic [15:0] rdata;
  } flow_regs_t;

  typedef struct packed {
    logic extPrev;
    logic held;
  } req_regs_t;

endpackage
`default_nettype wire

//--- hdl/dma_channel_req.sv
`include "dma_flow_map.svh"
`default_nettype none
module dma_channel_req (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Channel setup
  input wire logic [3:0] srcSel,
  input wire logic detectEdge,
  input wire logic burstMode,
  input wire logic chanOn,
  // Request inputs
  input wire logic extReqN,
  input wire logic [8:0] moduleReq,
  // Unit progress
  input wire logic unitDone,
  input wire logic lastUnit,
  // Results
  output logic pending,
  output logic withdraw
);
  import dma_flow_pkg::*;

  req_regs_t state_reg, state_next;
  logic isExt, isMod, isAuto, modSel, edgeMode, extFall;

  // Source decode; unlisted codes fall back to auto
  always_comb begin
    isExt = (srcSel == `SRC_EXT_DUAL) || (srcSel == `SRC_EXT_TO_DEV) || (srcSel == `SRC_EXT_FROM_DEV);
    isMod = ((srcSel >= `SRC_SER0_RX) && (srcSel <= `SRC_TIMER3)) || (srcSel == `SRC_CONV_END);
    isAuto = !isExt && !isMod;
    if (srcSel == `SRC_CONV_END) begin
      modSel = moduleReq[8];
    end else if (isMod) begin
      modSel = moduleReq[3'(srcSel - `SRC_SER0_RX)];
    end else begin
      modSel = 1'b0;
    end
  end

  // Edge sensing only counts in burst with edge select
  assign edgeMode = isExt && burstMode && detectEdge;
  assign extFall = state_reg.extPrev && !extReqN;

  // Latch for edge and burst module requests, dropped at the last unit
  always_comb begin
    state_next = state_reg;
    state_next.extPrev = extReqN;
    if (unitDone && lastUnit) begin
      state_next.held = 1'b0;
    end
    if ((edgeMode && extFall) || (isMod && burstMode && modSel)) begin
      state_next.held = 1'b1;
    end
    if (!chanOn) begin
      state_next.held = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '{extPrev: 1'b1, held: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Request decision; requester need not be source or destination
  always_comb begin
    pending = 1'b0;
    if (chanOn) begin
      if (isAuto) begin
        pending = 1'b1;
      end else if (isExt) begin
        pending = edgeMode ? state_reg.held : !extReqN;
      end else begin
        pending = burstMode ? (state_reg.held || modSel) : modSel;
      end
    end
  end

  // Withdraw: first unit in cycle steal, last unit in burst
  assign withdraw = unitDone && isMod && (!burstMode || lastUnit);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  edge_latch_a: assert property (chanOn && edgeMode && extFall && !(unitDone && lastUnit) |=> pending)
    else $error("falling edge not latched as a request");
  steal_withdraw_a: assert property (unitDone && isMod && !burstMode |-> withdraw)
    else $error("cycle-steal module request not withdrawn");
  burst_hold_a: assert property (unitDone && isMod && burstMode && !lastUnit |-> !withdraw)
    else $error("burst module request withdrawn early");
endmodule
`default_nettype wire

//--- hdl/dma_request_flow.sv
// Decided for this implementation: the address-and-strobe port and the register addresses.
`include "dma_flow_map.svh"
`default_nettype none
module dma_request_flow (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // External request pins
  input wire logic [3:0] extRequestN,
  output logic [3:0] extAcknowledge,
  // On-chip module requests
  input wire logic [1:0] serialRxFullReq,
  input wire logic [1:0] serialTxEmptyReq,
  input wire logic [3:0] timerCaptureMatchReq,
  input wire logic conversionEndReq,
  output logic [3:0] moduleReqWithdraw,
  // Transfer engine
  output logic xferReq,
  output logic [1:0] xferChannel,
  output logic xferWordSize,
  input wire logic xferDone,
  input wire logic addrErrorEvent,
  input wire logic nmiEvent,
  // Processor interrupts
  output logic [3:0] transferEndIrq
);
  import dma_flow_pkg::*;

  localparam flow_regs_t FLOW_RESET = '{
    ctrl: {4{`CTRL_RESET}},
    count: {4{`COUNT_RESET}},
    teSeen: 4'h0,
    irq: 4'h0,
    masterEn: 1'b0,
    nmiFlag: 1'b0,
    addrErrFlag: 1'b0,
    nmiSeen: 1'b0,
    aeSeen: 1'b0,
    prioSel: `PRIO_RESET,
    rrPos: `RR_RESET_POS,
    ch0Low: 1'b1,
    state: ST_IDLE,
    curCh: 2'h0,
    rdata: 16'h0000
  };

  flow_regs_t state_reg, state_next;
  logic [3:0] enabled, pending, isLast, unitDone;
  logic [8:0] moduleReq;
  logic [2:0] grant;

  // Module requests in source-code order
  assign moduleReq = {conversionEndReq, timerCaptureMatchReq, serialTxEmptyReq[1], serialRxFullReq[1],
                      serialTxEmptyReq[0], serialRxFullReq[0]};

  // Per-channel enable and request detection
  for (genvar i = 0; i < 4; i++) begin : gen_ch
    assign enabled[i] = state_reg.ctrl[i][`CTRL_ENABLE_BIT] && state_reg.masterEn
                        && !state_reg.ctrl[i][`CTRL_END_BIT] && !state_reg.nmiFlag
                        && !state_reg.addrErrFlag;
    assign unitDone[i] = xferReq && xferDone && (state_reg.curCh == 2'(i));
    assign isLast[i] = state_reg.count[i] == 16'h0001;
    assign extAcknowledge[i] = xferReq && (state_reg.curCh == 2'(i));

    dma_channel_req u_req (
      .clk(clk),
      .rst(rst),
      .srcSel(state_reg.ctrl[i][`CTRL_SRC_MSB:`CTRL_SRC_LSB]),
      .detectEdge(state_reg.ctrl[i][`CTRL_DETECT_BIT]),
      .burstMode(state_reg.ctrl[i][`CTRL_BURST_BIT]),
      .chanOn(enabled[i]),
      .extReqN(extRequestN[i]),
      .moduleReq(moduleReq),
      .unitDone(unitDone[i]),
      .lastUnit(isLast[i]),
      .pending(pending[i]),
      .withdraw(moduleReqWithdraw[i])
    );
  end

  // Pick the highest-priority pending channel; returns {found, channel}
  function automatic logic [2:0] pick(input logic [3:0] pend, input logic [1:0] prio,
                                      input logic [1:0] rrPos, input logic ch0Low);
    logic [3:0][1:0] ord;
    logic [2:0] res;
    ord = {2'h1, 2'h2, 2'h3, 2'h0};
    res = 3'h0;
    case (prio)
      `PRIO_FIXED0: ord = {2'h1, 2'h2, 2'h3, 2'h0};
      `PRIO_FIXED1: ord = {2'h0, 2'h2, 2'h3, 2'h1};
      `PRIO_RROBIN: begin
        // Cycle 0>3>2>1 rotated so the last served channel sits at the bottom
        for (int k = 0; k < 4; k++) begin
          ord[k] = 2'(2'h0 - rrPos - 2'(k));
        end
      end
      `PRIO_EXT_RR: ord = ch0Low ? {2'h0, 2'h1, 2'h2, 2'h3} : {2'h1, 2'h0, 2'h2, 2'h3};
      default: ord = {2'h1, 2'h2, 2'h3, 2'h0};
    endcase
    for (int k = 3; k >= 0; k--) begin
      if (pend[ord[k]]) begin
        res = {1'b1, ord[k]};
      end
    end
    return res;
  endfunction

  assign grant = pick(pending, state_reg.prioSel, state_reg.rrPos, state_reg.ch0Low);

  // Registers, then flow, then hardware flag sets so a set beats a clear
  always_comb begin
    state_next = state_reg;
    state_next.rdata = 16'h0000;
    // Register reads, arming the read-one-then-write-zero clears
    if (regRd) begin
      for (int i = 0; i < 4; i++) begin
        if (regAddr == 8'(`CH_CTRL_BASE + `CH_STRIDE * i)) begin
          state_next.rdata = state_reg.ctrl[i];
          if (state_reg.ctrl[i][`CTRL_END_BIT]) begin
            state_next.teSeen[i] = 1'b1;
          end
        end
        if (regAddr == 8'(`CH_COUNT_BASE + `CH_STRIDE * i)) begin
          state_next.rdata = state_reg.count[i];
        end
      end
      if (regAddr == `GLOBAL_OP_OFS) begin
        state_next.rdata[`GOP_MASTER_BIT] = state_reg.masterEn;
        state_next.rdata[`GOP_NMI_BIT] = state_reg.nmiFlag;
        state_next.rdata[`GOP_AE_BIT] = state_reg.addrErrFlag;
        state_next.rdata[`GOP_PRIO_MSB:`GOP_PRIO_LSB] = state_reg.prioSel;
        state_next.nmiSeen = state_reg.nmiSeen || state_reg.nmiFlag;
        state_next.aeSeen = state_reg.aeSeen || state_reg.addrErrFlag;
      end
    end
    // Register writes; flags clear only after being read as one
    if (regWr) begin
      for (int i = 0; i < 4; i++) begin
        if (regAddr == 8'(`CH_CTRL_BASE + `CH_STRIDE * i)) begin
          state_next.ctrl[i] = (regWdata & `CTRL_WMASK) | (state_reg.ctrl[i] & ~`CTRL_WMASK);
          if (!regWdata[`CTRL_END_BIT] && state_reg.teSeen[i]) begin
            state_next.ctrl[i][`CTRL_END_BIT] = 1'b0;
            state_next.teSeen[i] = 1'b0;
          end
        end
        if (regAddr == 8'(`CH_COUNT_BASE + `CH_STRIDE * i)) begin
          state_next.count[i] = regWdata;
        end
      end
      if (regAddr == `GLOBAL_OP_OFS) begin
        state_next.masterEn = regWdata[`GOP_MASTER_BIT];
        state_next.prioSel = regWdata[`GOP_PRIO_MSB:`GOP_PRIO_LSB];
        if (!regWdata[`GOP_NMI_BIT] && state_reg.nmiSeen) begin
          state_next.nmiFlag = 1'b0;
          state_next.nmiSeen = 1'b0;
        end
        if (!regWdata[`GOP_AE_BIT] && state_reg.aeSeen) begin
          state_next.addrErrFlag = 1'b0;
          state_next.aeSeen = 1'b0;
        end
      end
    end
    // Transfer flow, one unit per grant
    case (state_reg.state)
      ST_IDLE: begin
        if (grant[2]) begin
          state_next.state = ST_BUSY;
          state_next.curCh = grant[1:0];
        end
      end
      ST_BUSY: begin
        if (!enabled[state_reg.curCh]) begin
          // Abort: no count change, end flag untouched
          state_next.state = ST_IDLE;
        end else if (xferDone) begin
          state_next.state = ST_IDLE;
          state_next.count[state_reg.curCh] = state_reg.count[state_reg.curCh] - 16'h0001;
          state_next.rrPos = 2'(2'h1 - state_reg.curCh);
          if (state_reg.curCh == 2'h0) begin
            state_next.ch0Low = 1'b1;
          end else if (state_reg.curCh == 2'h1) begin
            state_next.ch0Low = 1'b0;
          end
          if (isLast[state_reg.curCh]) begin
            state_next.ctrl[state_reg.curCh][`CTRL_END_BIT] = 1'b1;
          end
        end
      end
      default: state_next.state = ST_IDLE;
    endcase
    // Abort events latch and block every channel
    if (nmiEvent) begin
      state_next.nmiFlag = 1'b1;
    end
    if (addrErrorEvent) begin
      state_next.addrErrFlag = 1'b1;
    end
    for (int i = 0; i < 4; i++) begin
      state_next.irq[i] = state_next.ctrl[i][`CTRL_END_BIT] && state_next.ctrl[i][`CTRL_IE_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= FLOW_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Request is dropped the same cycle the channel loses its enable
  assign xferReq = (state_reg.state == ST_BUSY) && enabled[state_reg.curCh];
  assign xferChannel = state_reg.curCh;
  assign xferWordSize = state_reg.ctrl[state_reg.curCh][`CTRL_SIZE_BIT];
  assign regRdata = state_reg.rdata;
  assign transferEndIrq = state_reg.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  enable_gate_a: assert property (xferReq |-> state_reg.masterEn && !state_reg.nmiFlag && !state_reg.addrErrFlag)
    else $error("transfer requested while blocked");
  count_step_a: assert property (xferReq && xferDone |=> state_reg.count[$past(state_reg.curCh)]
                                 == 16'($past(state_reg.count[state_reg.curCh]) - 16'h0001))
    else $error("count not decremented by one");
  auto_start_a: assert property (state_reg.state == ST_IDLE && enabled[0] && state_reg.prioSel == `PRIO_FIXED0
                                 && state_reg.ctrl[0][`CTRL_SRC_MSB:`CTRL_SRC_LSB] == 4'h1
                                 |=> xferReq && xferChannel == 2'h0)
    else $error("auto request did not start");
  normal_end_a: assert property (xferReq && xferDone && isLast[state_reg.curCh]
                                 |=> state_reg.ctrl[$past(state_reg.curCh)][`CTRL_END_BIT])
    else $error("end flag not set at zero count");
  end_irq_a: assert property ($rose(state_reg.ctrl[0][`CTRL_END_BIT]) && state_reg.ctrl[0][`CTRL_IE_BIT]
                              |-> transferEndIrq[0])
    else $error("end interrupt missing");
  nmi_abort_a: assert property (nmiEvent |=> !xferReq ##1 !xferReq)
    else $error("transfer continued after NMI");
  master_abort_a: assert property (regWr && regAddr == `GLOBAL_OP_OFS && !regWdata[`GOP_MASTER_BIT]
                                   |=> !xferReq)
    else $error("transfer continued after master disable");
  abort_no_end_a: assert property (state_reg.state == ST_BUSY && !xferReq
                                   |=> state_reg.ctrl[$past(state_reg.curCh)][`CTRL_END_BIT]
                                       == $past(state_reg.ctrl[state_reg.curCh][`CTRL_END_BIT]))
    else $error("end flag changed on abort");
  fixed_prio_a: assert property (state_reg.state == ST_IDLE && state_reg.prioSel == `PRIO_FIXED1
                                 && pending[1] |=> xferChannel == 2'h1)
    else $error("fixed priority order violated");
  flag_block_a: assert property (state_reg.addrErrFlag && !regWr |=> state_reg.addrErrFlag && !xferReq)
    else $error("address error flag did not block");
  grant_a: assert property (state_reg.state == ST_IDLE && grant[2] |=> state_reg.state == ST_BUSY)
    else $error("pending request not started");

  normal_end_c: cover property (xferReq && xferDone && isLast[state_reg.curCh]);
  abort_c: cover property (state_reg.state == ST_BUSY && !xferReq);
  rrobin_c: cover property (state_reg.prioSel == `PRIO_RROBIN && xferDone ##[1:4] xferReq);
  withdraw_c: cover property (|moduleReqWithdraw);
endmodule
`default_nettype wire

//--- verif/dma_far_side_model.sv
`default_nettype none
module dma_far_side_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Transfer engine
  input wire logic xferReq,
  input wire logic [3:0] engDelay,
  output logic xferDone,
  // Request pins and modules
  input wire logic [3:0] extAssert,
  output logic [3:0] extRequestN,
  input wire logic [8:0] raise,
  input wire logic [3:0][3:0] chanSrc,
  input wire logic [3:0] moduleReqWithdraw,
  output logic [1:0] serialRxFullReq,
  output logic [1:0] serialTxEmptyReq,
  output logic [3:0] timerCaptureMatchReq,
  output logic conversionEndReq
);
  logic [3:0] waitCnt;
  logic [8:0] reqHeld;
  logic [8:0] dropMask;

  // Engine moves one unit after engDelay cycles; a slow engine exposes aborts
  assign xferDone = xferReq && (waitCnt == engDelay);
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      waitCnt <= 4'h0;
    else if (!xferReq || xferDone)
      waitCnt <= 4'h0;
    else
      waitCnt <= waitCnt + 4'h1;
  end

  // Pins have pull-ups, so a released request reads high
  assign extRequestN = ~extAssert;

  // Which module line each channel's withdraw pulse clears
  always_comb begin
    dropMask = 9'h000;
    for (int c = 0; c < 4; c++) begin
      if (moduleReqWithdraw[c] && chanSrc[c] == 4'hD)
        dropMask[8] = 1'b1;
      else if (moduleReqWithdraw[c] && chanSrc[c] inside {[4'h4:4'hB]})
        dropMask[chanSrc[c] - 4'h4] = 1'b1;
    end
  end

  // Interrupt output enabled: the line stays up until the controller withdraws it
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      reqHeld <= 9'h000;
    else
      reqHeld <= (reqHeld & ~dropMask) | raise;
  end
  assign serialRxFullReq = {reqHeld[2], reqHeld[0]};
  assign serialTxEmptyReq = {reqHeld[3], reqHeld[1]};
  assign timerCaptureMatchReq = reqHeld[7:4];
  assign conversionEndReq = reqHeld[8];
endmodule
`default_nettype wire

//--- verif/dma_request_flow_test.sv
`include "dma_flow_map.svh"
`default_nettype none
module dma_request_flow_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, regWr, regRd, xferDone, addrErrorEvent, nmiEvent, conversionEndReq, xferReq;
  logic xferWordSize, sizeSeen;
  logic [7:0] regAddr;
  logic [15:0] regWdata, regRdata, rdv;
  logic [3:0] extRequestN, extAcknowledge, timerCaptureMatchReq, moduleReqWithdraw, transferEndIrq;
  logic [3:0] engDelay, extAssert;
  logic [1:0] serialRxFullReq, serialTxEmptyReq, xferChannel;
  logic [8:0] raise;
  logic [3:0][3:0] chanSrc;
  int fails, n_checks, acks, firstCh;
  int units[4];
  int wds[4];

  dma_request_flow u_dma_request_flow (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extRequestN(extRequestN),
    .extAcknowledge(extAcknowledge), .serialRxFullReq(serialRxFullReq), .serialTxEmptyReq(serialTxEmptyReq),
    .timerCaptureMatchReq(timerCaptureMatchReq), .conversionEndReq(conversionEndReq),
    .moduleReqWithdraw(moduleReqWithdraw), .xferReq(xferReq), .xferChannel(xferChannel),
    .xferWordSize(xferWordSize), .xferDone(xferDone), .addrErrorEvent(addrErrorEvent), .nmiEvent(nmiEvent),
    .transferEndIrq(transferEndIrq));

  dma_far_side_model u_dma_far_side_model (.clk(clk), .rst(rst), .xferReq(xferReq), .engDelay(engDelay),
    .xferDone(xferDone), .extAssert(extAssert), .extRequestN(extRequestN), .raise(raise), .chanSrc(chanSrc),
    .moduleReqWithdraw(moduleReqWithdraw), .serialRxFullReq(serialRxFullReq),
    .serialTxEmptyReq(serialTxEmptyReq), .timerCaptureMatchReq(timerCaptureMatchReq),
    .conversionEndReq(conversionEndReq));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Tally units, acknowledges and withdraw pulses from pre-edge values
  always @(posedge clk) begin
    if (xferReq && xferDone) begin
      if (firstCh < 0)
        firstCh = xferChannel;
      units[xferChannel]++;
      sizeSeen = xferWordSize;
      if (extAcknowledge[xferChannel])
        acks++;
    end
    for (int c = 0; c < 4; c++)
      if (moduleReqWithdraw[c])
        wds[c]++;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] ctrlA(input logic [1:0] ch);
    return `CH_CTRL_BASE + `CH_STRIDE * {6'h00, ch};
  endfunction

  // One-cycle strobes, launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask

  task automatic setup(input logic [1:0] ch, input logic [15:0] ctl, input logic [15:0] cnt);
    wr(ctrlA(ch) + `CH_COUNT_BASE, cnt);
    wr(ctrlA(ch), ctl);
  endtask

  // Read the end flag as 1, then write 0
  task automatic endClr(input logic [1:0] ch);
    rd(ctrlA(ch));
    wr(ctrlA(ch), 16'h0000);
  endtask

  task automatic zero();
    acks = 0;
    firstCh = -1;
    for (int c = 0; c < 4; c++) begin
      units[c] = 0;
      wds[c] = 0;
    end
  endtask

  // Bounded wait; a hang ends the run as a failure
  task automatic waitUnits(input int ch, input int n);
    int i;
    for (i = 0; i < 400 && units[ch] < n; i++)
      @(posedge clk);
    if (i == 400) begin
      fails++;
      give_verdict();
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset();
    rd(`GLOBAL_OP_OFS);
    check("global", rdv, 16'h0000);
    rd(ctrlA(2));
    check("ctrl2", rdv, 16'h0000);
    rd(8'h80);
    check("unmapped", rdv, 16'h0000);
    $display("reset test done");
  endtask

  task automatic t_auto();
    zero();
    setup(0, 16'h0105, 16'h0003);
    wr(`GLOBAL_OP_OFS, 16'h0001);
    waitUnits(0, 3);
    repeat (8) @(posedge clk);
    check("auto units", 16'(units[0]), 16'h0003);
    check("auto size", {15'h0000, sizeSeen}, 16'h0000);
    rd(8'h04);
    check("auto count", rdv, 16'h0000);
    check("end irq", {12'h000, transferEndIrq}, 16'h0001);
    wr(8'h04, 16'h0002);
    repeat (10) @(posedge clk);
    check("blocked by end", 16'(units[0]), 16'h0003);
    endClr(0);
    check("end flag seen", rdv, 16'h0107);
    rd(ctrlA(0));
    check("end flag clear", rdv, 16'h0000);
    check("irq clear", {12'h000, transferEndIrq}, 16'h0000);
    $display("auto test done");
  endtask

  // Event abort, then flag blocks until read-1/write-0
  task automatic t_events();
    for (int e = 0; e < 2; e++) begin
      zero();
      engDelay <= 4'h6;
      setup(1, 16'h0101, 16'h0005);
      waitUnits(1, 1);
      nmiEvent <= (e == 0);
      addrErrorEvent <= (e == 1);
      @(posedge clk);
      nmiEvent <= 1'b0;
      addrErrorEvent <= 1'b0;
      repeat (12) @(posedge clk);
      check("event units", 16'(units[1]), 16'h0001);
      rd(ctrlA(1) + `CH_COUNT_BASE);
      check("event count", rdv, 16'h0004);
      rd(ctrlA(1));
      check("no end flag", rdv, 16'h0101);
      rd(`GLOBAL_OP_OFS);
      check("event flag", rdv, (e == 0) ? 16'h0003 : 16'h0005);
      wr(`GLOBAL_OP_OFS, 16'h0001);
      waitUnits(1, 5);
      endClr(1);
      check("resumed", rdv, 16'h0103);
    end
    engDelay <= 4'h0;
    $display("event abort test done");
  endtask

  // Channel enable cleared, then master enable cleared
  task automatic t_disable();
    for (int k = 0; k < 2; k++) begin
      zero();
      engDelay <= 4'h6;
      setup(2, 16'h0101, 16'h000A);
      waitUnits(2, 1);
      wr(k == 0 ? ctrlA(2) : `GLOBAL_OP_OFS, k == 0 ? 16'h0100 : 16'h0000);
      repeat (12) @(posedge clk);
      check("disable units", 16'(units[2]), 16'h0001);
      rd(ctrlA(2) + `CH_COUNT_BASE);
      check("disable count", rdv, 16'h0009);
      rd(ctrlA(2));
      check("disable flag", rdv, (k == 0) ? 16'h0100 : 16'h0101);
      wr(ctrlA(2), 16'h0000);
      wr(`GLOBAL_OP_OFS, 16'h0001);
    end
    engDelay <= 4'h0;
    $display("disable test done");
  endtask

  task automatic t_ext_level();
    logic [3:0] codes [3] = '{4'h0, 4'h2, 4'h3};
    for (int i = 0; i < 3; i++) begin
      zero();
      setup(0, {4'h0, codes[i], 8'h01}, 16'h0002);
      repeat (10) @(posedge clk);
      check("pin high", 16'(units[0]), 16'h0000);
      extAssert[0] <= 1'b1;
      waitUnits(0, 2);
      extAssert[0] <= 1'b0;
      check("level units", 16'(units[0]), 16'h0002);
      check("acknowledges", 16'(acks), 16'h0002);
      endClr(0);
    end
    $display("external level test done");
  endtask

  // One falling edge is latched for the whole burst
  task automatic t_ext_edge();
    zero();
    setup(0, 16'h0051, 16'h0003);
    extAssert[0] <= 1'b1;
    @(posedge clk);
    extAssert[0] <= 1'b0;
    waitUnits(0, 3);
    check("edge units", 16'(units[0]), 16'h0003);
    endClr(0);
    $display("external edge test done");
  endtask

  // All nine module sources in cycle steal, then timer 0 in burst
  task automatic t_module();
    logic [3:0] codes [9] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hD};
    for (int i = 0; i < 9; i++) begin
      zero();
      chanSrc[3] <= codes[i];
      setup(3, {4'h0, codes[i], 8'h01}, 16'h0002);
      for (int r = 0; r < 2; r++) begin
        raise <= 9'h001 << ((codes[i] == 4'hD) ? 8 : codes[i] - 4'h4);
        @(posedge clk);
        raise <= 9'h000;
        waitUnits(3, r + 1);
        repeat (10) @(posedge clk);
        check("steal units", 16'(units[3]), 16'(r + 1));
        check("steal withdraws", 16'(wds[3]), 16'(r + 1));
      end
      endClr(3);
    end
    zero();
    // Timer 0 line, so the model clears the right request on withdraw
    chanSrc[3] <= 4'h8;
    setup(3, 16'h0819, 16'h0003);
    raise <= 9'h010;
    @(posedge clk);
    raise <= 9'h000;
    waitUnits(3, 3);
    check("burst withdraws", 16'(wds[3]), 16'h0001);
    check("word size", {15'h0000, sizeSeen}, 16'h0001);
    endClr(3);
    $display("module request test done");
  endtask

  task automatic t_prio();
    for (int p = 0; p < 2; p++) begin
      wr(`GLOBAL_OP_OFS, 16'h0000);
      zero();
      setup(0, 16'h0F01, 16'h0001);
      setup(1, 16'h0F01, 16'h0001);
      wr(`GLOBAL_OP_OFS, 16'h0001 | 16'(p << 8));
      waitUnits(0, 1);
      waitUnits(1, 1);
      check("first channel", 16'(firstCh), 16'(p));
      endClr(0);
      endClr(1);
    end
    $display("priority test done");
  endtask

  // Main sequence; address choices stay with software here
  initial begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 16'h0000;
    nmiEvent = 1'b0;
    addrErrorEvent = 1'b0;
    engDelay = 4'h0;
    extAssert = 4'h0;
    raise = 9'h000;
    chanSrc = '0;
    fails = 0;
    n_checks = 0;
    zero();
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_auto();
    t_events();
    t_disable();
    t_ext_level();
    t_ext_edge();
    t_module();
    t_prio();
    give_verdict();
  end
endmodule
`default_nettype wire
